// file: sim/cts_sequencer_props.sv
// Watches the sequencer ports for bus and sensor clock relations.
module cts_sequencer_props #(
    parameter int unsigned CLEAN_LEN = 64,
    parameter int unsigned SHIFT_LEN = 32,
    parameter int unsigned READ_LEN = 256
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trig_pin,
    input wire cts_pkg::cts_ccdclk_t ccd_clk,
    input wire logic fire
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus answers and sensor clock relations.
    setup_answer_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    patdat_zero_a: assert property (psel && !penable && !pwrite && paddr == 8'h18 |=> prdata == 32'h0)
        else $error("pattern data read not zero");
    vert_stop_a: assert property (fire |-> !ccd_clk.image && !ccd_clk.storage)
        else $error("vertical clock during exposure");
    horiz_run_a: assert property (fire && $past(fire) |-> ccd_clk.horiz != $past(ccd_clk.horiz))
        else $error("horizontal clock stopped");
    shift_after_a: assert property ($fell(fire) |-> (ccd_clk.image && ccd_clk.storage) || ccd_clk == 3'h0)
        else $error("exposure end without shift");
    exposure_c: cover property ($fell(fire));
    refused_c: cover property (pslverr);
    shift_c: cover property (ccd_clk.image && ccd_clk.storage && !ccd_clk.horiz);
endmodule

bind cts_sequencer cts_sequencer_props #(.CLEAN_LEN(CLEAN_LEN), .SHIFT_LEN(SHIFT_LEN), .READ_LEN(READ_LEN)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin),
    .ccd_clk(ccd_clk), .fire(fire));

// file: sim/cts_sequencer_tb.sv
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
// Register and trigger sequences with expected exposure lengths.
module cts_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trig_pin, fire, go;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] wid;
    cts_pkg::cts_ccdclk_t ccd_clk;
    int miscompares, num_checks;

    cts_sequencer #(.CLEAN_LEN(4), .SHIFT_LEN(4), .READ_LEN(8)) i_cts_sequencer (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin), .ccd_clk(ccd_clk), .fire(fire));
    cts_trig_src i_cts_trig_src (.pclk(pclk), .presetn(presetn), .go(go), .width(wid), .trig_pin(trig_pin));

    // Clock of 100 ns period.
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (!pready);
        `CHK("wait states", 1, n)
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(nm, x, r)
    endtask

    // Polls the state field until it shows one of the states in ok.
    task automatic settle(input logic [6:0] ok);
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        do
        begin
            apb(1'b0, cts_pkg::REG_STATUS, 32'h0, r, e);
            n++;
        end
        while ((r[14:8] & ok) == 7'h0 && n < 200);
        `CHK("settle", 1'b1, (r[14:8] & ok) != 7'h0)
    endtask

    task automatic pulse(input logic [15:0] w);
        @(posedge pclk);
        go <= 1'b1;
        wid <= w;
        @(posedge pclk);
        go <= 1'b0;
    endtask

    // Sends one trigger and measures how many cycles fire stays high.
    task automatic shot(input logic [15:0] w, input int x, input logic [6:0] ok, input string nm);
        int n, len;
        pulse(w);
        n = 0;
        while (!fire && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        len = 0;
        while (fire && len < 200)
        begin
            @(posedge pclk);
            len++;
        end
        `CHK(nm, x, len)
        `CHK({nm, " end"}, 1'b0, fire)
        // An accepted trigger shows fire four edges after the pulse request.
        if (x != 0)
            `CHK({nm, " latency"}, 4, n)
        settle(ok);
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        logic [31:0] r;
        logic e;
        logic h;
        {presetn, psel, penable, pwrite, go, paddr, pwdata, wid} = '0;
        miscompares = 0;
        num_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(cts_pkg::REG_CTRL, 32'h0, "ctrl");
        rd(cts_pkg::REG_DELAY, 32'h0, "delay");
        rd(cts_pkg::REG_NIMG, 32'h1, "nimg");
        rd(cts_pkg::REG_MINCLN, 32'h4, "mincln");
        rd(cts_pkg::REG_PATIDX, 32'h0, "patidx");
        rd(cts_pkg::REG_PATDAT, 32'h0, "patdat");
        rd(cts_pkg::REG_STATUS, 32'h100, "status");
        apb(1'b0, 8'h1C, 32'h0, r, e);
        `CHK("unmapped", 1'b1, e)
        $display("test reset done");
        wr(cts_pkg::REG_MINCLN, 32'h3);
        wr(cts_pkg::REG_PATDAT, 32'h5);
        wr(cts_pkg::REG_CTRL, 32'h3);
        shot(16'h2, 0, 7'h02, "early trig");
        // A mode change mid-series must not lift the minimum clean count.
        wr(cts_pkg::REG_CTRL, 32'h5);
        shot(16'h2, 5, 7'h02, "ext expose");
        shot(16'h2, 0, 7'h02, "min cleans");
        wr(cts_pkg::REG_CTRL, 32'h0);
        $display("test ext done");
        wr(cts_pkg::REG_CTRL, 32'h5);
        shot(16'h2, 5, 7'h02, "fast 1");
        shot(16'h2, 5, 7'h02, "fast 2");
        wr(cts_pkg::REG_CTRL, 32'h0);
        wr(cts_pkg::REG_PATIDX, 32'h1);
        wr(cts_pkg::REG_PATDAT, 32'h6);
        wr(cts_pkg::REG_CTRL, 32'h1D);
        shot(16'h2, 5, 7'h02, "ring 0");
        shot(16'h2, 6, 7'h02, "ring 1");
        shot(16'h2, 5, 7'h02, "ring wrap");
        wr(cts_pkg::REG_CTRL, 32'h0);
        $display("test fast done");
        wr(cts_pkg::REG_MINCLN, 32'h0);
        wr(cts_pkg::REG_CTRL, 32'h7);
        shot(16'h7, 7, 7'h02, "level");
        wr(cts_pkg::REG_CTRL, 32'h0);
        $display("test level done");
        wr(cts_pkg::REG_DELAY, 32'h3);
        wr(cts_pkg::REG_NIMG, 32'h2);
        wr(cts_pkg::REG_CTRL, 32'h1);
        shot(16'h2, 4, 7'h40, "ft delay");
        // While waiting only the horizontal clock may toggle.
        `CHK("wait vclk", 2'h0, {ccd_clk.image, ccd_clk.storage})
        h = ccd_clk.horiz;
        @(posedge pclk);
        `CHK("wait hclk", ~h, ccd_clk.horiz)
        pulse(16'h2);
        settle(7'h01);
        rd(cts_pkg::REG_CTRL, 32'h0, "ft run");
        rd(cts_pkg::REG_STATUS, 32'h0002_0100, "ft status");
        $display("test ft done");
        results();
    end

    // Cuts a hang short.
    initial
    begin
        repeat (30000) @(posedge pclk);
        miscompares++;
        $display("[FAIL] watchdog exp finish got timeout");
        results();
    end
endmodule

// file: sim/cts_trig_src.sv
// Trigger source on the far side: one high pulse of a given width per request.
module cts_trig_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [15:0] width,
    output logic trig_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] left;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            left <= 16'h0;
        else if (go)
            left <= width;
        else if (left != 16'h0)
            left <= left - 16'h1;
    end
    assign trig_pin = (left != 16'h0);
endmodule

// file: verilog/cts_pat_store.sv
// Flip-flop table of exposure timing patterns, one write port, one read port.
module cts_pat_store #(
    parameter int DEPTH = cts_pkg::NUM_PAT,
    parameter int IW = cts_pkg::PAT_IW,
    parameter int W = cts_pkg::PAT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [IW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [IW-1:0] raddr,
    output logic [W-1:0] rdata
);

    logic [W-1:0] mem [DEPTH];

    // One storage word per entry, each loaded when its index is written.
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_ent
        logic [W-1:0] next_word;

        always_comb
        begin
            next_word = mem[i];
            if (we && (waddr == IW'(i)))
                next_word = wdata;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                mem[i] <= W'(cts_pkg::RST_PATTERN);
            else
                mem[i] <= next_word;
        end
    end

    assign rdata = mem[raddr];

endmodule

// file: verilog/cts_pkg.sv
package cts_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DELAY = 8'h04;
    localparam logic [7:0] REG_NIMG = 8'h08;
    localparam logic [7:0] REG_MINCLN = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PATIDX = 8'h14;
    localparam logic [7:0] REG_PATDAT = 8'h18;

    // Control register field positions.
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_RING = 3;
    localparam int CTRL_PLAST = 4;

    // Status register field positions.
    localparam int STAT_BUSY = 0;
    localparam int STAT_PAT = 4;
    localparam int STAT_STATE = 8;
    localparam int STAT_IMGS = 16;

    // Reset values of the software registers.
    localparam logic [31:0] RST_DELAY = 32'h0000_0000;
    localparam logic [15:0] RST_NIMG = 16'h0001;
    localparam logic [15:0] RST_MINCLN = 16'h0004;
    localparam logic [31:0] RST_PATTERN = 32'h0000_0001;

    // Pattern table geometry.
    localparam int NUM_PAT = 16;
    localparam int PAT_IW = 4;
    localparam int PAT_W = 32;

    // External trigger modes.
    typedef enum logic [1:0] {
        MODE_FT = 2'h0,
        MODE_EXT = 2'h1,
        MODE_FAST = 2'h2,
        MODE_LEVEL = 2'h3
    } cts_mode_t;

    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_CLEAN = 7'h02,
        ST_DELAY = 7'h04,
        ST_EXPOSE = 7'h08,
        ST_SHIFT = 7'h10,
        ST_READ = 7'h20,
        ST_WAIT = 7'h40
    } cts_state_t;

    // Sensor clock phases driven out to the CCD drivers.
    typedef struct packed {
        logic image;
        logic storage;
        logic horiz;
    } cts_ccdclk_t;

    // Trigger input after synchronisation.
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } cts_trig_t;

endpackage

// file: verilog/cts_sequencer.sv
module cts_sequencer #(
    parameter int unsigned CLEAN_LEN = 64,
    parameter int unsigned SHIFT_LEN = 32,
    parameter int unsigned READ_LEN = 256
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trig_pin,
    output cts_pkg::cts_ccdclk_t ccd_clk,
    output logic fire
);

    cts_pkg::cts_trig_t trig;
    logic [31:0] pat_rdata;

    // Software registers.
    logic run;
    cts_pkg::cts_mode_t mode_cfg;
    logic ring;
    logic [3:0] pat_last;
    logic [31:0] delay_cfg;
    logic [15:0] nimg_cfg;
    logic [15:0] mincln_cfg;
    logic [3:0] pat_widx;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_run;
    cts_pkg::cts_mode_t next_mode_cfg;
    logic next_ring;
    logic [3:0] next_pat_last;
    logic [31:0] next_delay_cfg;
    logic [15:0] next_nimg_cfg;
    logic [15:0] next_mincln_cfg;
    logic [3:0] next_pat_widx;

    // Sequencer state.
    cts_pkg::cts_state_t state;
    cts_pkg::cts_mode_t act_mode;
    logic [31:0] cnt;
    logic [15:0] cleans;
    logic [15:0] imgs;
    logic [3:0] pat_idx;
    logic [31:0] exp_len;
    logic hw_stop;
    cts_pkg::cts_state_t next_state;
    cts_pkg::cts_mode_t next_act_mode;
    logic [31:0] next_cnt;
    logic [15:0] next_cleans;
    logic [15:0] next_imgs;
    logic [3:0] next_pat_idx;
    logic [31:0] next_exp_len;
    logic next_hw_stop;
    cts_pkg::cts_ccdclk_t next_ccd_clk;
    logic next_fire;
    logic accept;
    logic wr_en;
    logic pat_we;

    cts_trig_sync u_trig (
        .pclk(pclk),
        .presetn(presetn),
        .trig_pin(trig_pin),
        .trig(trig)
    );

    cts_pat_store u_pat (
        .pclk(pclk),
        .presetn(presetn),
        .we(pat_we),
        .waddr(pat_widx),
        .wdata(pwdata),
        .raddr(pat_idx),
        .rdata(pat_rdata)
    );

    // A write lands on the access edge where pready is high.
    assign wr_en = psel & penable & pwrite & pready;
    assign pat_we = wr_en && (paddr == cts_pkg::REG_PATDAT);

    // APB slave: one wait-free access phase, read data caught in setup.
    always_comb
    begin
        next_pready = psel & ~penable;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        next_run = run;
        next_mode_cfg = mode_cfg;
        next_ring = ring;
        next_pat_last = pat_last;
        next_delay_cfg = delay_cfg;
        next_nimg_cfg = nimg_cfg;
        next_mincln_cfg = mincln_cfg;
        next_pat_widx = pat_widx;
        if (psel && !penable)
        begin
            next_prdata = 32'h0000_0000;
            if (paddr == cts_pkg::REG_CTRL)
            begin
                next_prdata[cts_pkg::CTRL_RUN] = run;
                next_prdata[cts_pkg::CTRL_MODE +: 2] = mode_cfg;
                next_prdata[cts_pkg::CTRL_RING] = ring;
                next_prdata[cts_pkg::CTRL_PLAST +: 4] = pat_last;
            end
            else if (paddr == cts_pkg::REG_DELAY)
                next_prdata = delay_cfg;
            else if (paddr == cts_pkg::REG_NIMG)
                next_prdata[15:0] = nimg_cfg;
            else if (paddr == cts_pkg::REG_MINCLN)
                next_prdata[15:0] = mincln_cfg;
            else if (paddr == cts_pkg::REG_STATUS)
            begin
                next_prdata[cts_pkg::STAT_BUSY] = (state != cts_pkg::ST_IDLE);
                next_prdata[cts_pkg::STAT_PAT +: 4] = pat_idx;
                next_prdata[cts_pkg::STAT_STATE +: 7] = state;
                next_prdata[cts_pkg::STAT_IMGS +: 16] = imgs;
            end
            else if (paddr == cts_pkg::REG_PATIDX)
                next_prdata[3:0] = pat_widx;
            else if (paddr == cts_pkg::REG_PATDAT)
                next_prdata = 32'h0000_0000;
            else
                next_pslverr = 1'b1;
        end
        // The sequencer drops run when a frame-transfer series is complete.
        if (hw_stop)
            next_run = 1'b0;
        if (wr_en)
        begin
            if (paddr == cts_pkg::REG_CTRL)
            begin
                next_run = pwdata[cts_pkg::CTRL_RUN];
                next_mode_cfg = cts_pkg::cts_mode_t'(pwdata[cts_pkg::CTRL_MODE +: 2]);
                next_ring = pwdata[cts_pkg::CTRL_RING];
                next_pat_last = pwdata[cts_pkg::CTRL_PLAST +: 4];
            end
            else if (paddr == cts_pkg::REG_DELAY)
                next_delay_cfg = pwdata;
            else if (paddr == cts_pkg::REG_NIMG)
                next_nimg_cfg = pwdata[15:0];
            else if (paddr == cts_pkg::REG_MINCLN)
                next_mincln_cfg = pwdata[15:0];
            else if (paddr == cts_pkg::REG_PATIDX)
                next_pat_widx = pwdata[3:0];
        end
    end

    // Registers of the bus slave.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            run <= 1'b0;
            mode_cfg <= cts_pkg::MODE_FT;
            ring <= 1'b0;
            pat_last <= 4'h0;
            delay_cfg <= cts_pkg::RST_DELAY;
            nimg_cfg <= cts_pkg::RST_NIMG;
            mincln_cfg <= cts_pkg::RST_MINCLN;
            pat_widx <= 4'h0;
        end
        else
        begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            run <= next_run;
            mode_cfg <= next_mode_cfg;
            ring <= next_ring;
            pat_last <= next_pat_last;
            delay_cfg <= next_delay_cfg;
            nimg_cfg <= next_nimg_cfg;
            mincln_cfg <= next_mincln_cfg;
            pat_widx <= next_pat_widx;
        end
    end

    assign accept = (act_mode == cts_pkg::MODE_FT) || (act_mode == cts_pkg::MODE_FAST)
        || (cleans >= mincln_cfg);

    // Sequencer next-state logic.
    always_comb
    begin
        next_state = state;
        next_act_mode = act_mode;
        next_cnt = cnt + 32'h0000_0001;
        next_cleans = cleans;
        next_imgs = imgs;
        next_pat_idx = pat_idx;
        next_exp_len = exp_len;
        next_hw_stop = 1'b0;
        case (state)
            cts_pkg::ST_IDLE:
            begin
                next_cnt = 32'h0000_0000;
                if (run && !hw_stop)
                begin
                    next_act_mode = mode_cfg;
                    next_imgs = 16'h0000;
                    next_cleans = 16'h0000;
                    next_pat_idx = 4'h0;
                    next_state = cts_pkg::ST_CLEAN;
                end
            end
            cts_pkg::ST_CLEAN:
            begin
                if (cnt == 32'(CLEAN_LEN - 1))
                begin
                    next_cnt = 32'h0000_0000;
                    if (cleans != 16'hFFFF)
                        next_cleans = cleans + 16'h0001;
                end
                if (!run)
                    next_state = cts_pkg::ST_IDLE;
                else if (trig.rise && accept)
                begin
                    next_cnt = 32'h0000_0000;
                    next_exp_len = (pat_rdata == 32'h0000_0000) ? 32'h0000_0001 : pat_rdata;
                    if (ring)
                        next_pat_idx = (pat_idx == pat_last) ? 4'h0 : pat_idx + 4'h1;
                    if (act_mode == cts_pkg::MODE_FT)
                        next_state = cts_pkg::ST_DELAY;
                    else
                        next_state = cts_pkg::ST_EXPOSE;
                end
            end
            cts_pkg::ST_DELAY:
            begin
                if (cnt >= delay_cfg)
                begin
                    next_cnt = 32'h0000_0000;
                    next_state = cts_pkg::ST_SHIFT;
                end
            end
            cts_pkg::ST_EXPOSE:
            begin
                if (act_mode == cts_pkg::MODE_LEVEL)
                begin
                    if (trig.fall || !trig.level)
                    begin
                        next_cnt = 32'h0000_0000;
                        next_state = cts_pkg::ST_SHIFT;
                    end
                end
                else if (next_cnt >= exp_len)
                begin
                    next_cnt = 32'h0000_0000;
                    next_state = cts_pkg::ST_SHIFT;
                end
            end
            cts_pkg::ST_SHIFT:
            begin
                if (cnt == 32'(SHIFT_LEN - 1))
                begin
                    next_cnt = 32'h0000_0000;
                    next_state = cts_pkg::ST_READ;
                end
            end
            cts_pkg::ST_READ:
            begin
                if (cnt == 32'(READ_LEN - 1))
                begin
                    next_cnt = 32'h0000_0000;
                    next_imgs = imgs + 16'h0001;
                    if (act_mode == cts_pkg::MODE_FT)
                    begin
                        if (next_imgs >= nimg_cfg)
                        begin
                            next_hw_stop = 1'b1;
                            next_state = cts_pkg::ST_IDLE;
                        end
                        else
                            next_state = cts_pkg::ST_WAIT;
                    end
                    else
                    begin
                        next_cleans = 16'h0000;
                        next_state = cts_pkg::ST_CLEAN;
                    end
                end
            end
            cts_pkg::ST_WAIT:
            begin
                next_cnt = 32'h0000_0000;
                if (!run)
                    next_state = cts_pkg::ST_IDLE;
                else if (trig.rise)
                begin
                    if (ring)
                        next_pat_idx = (pat_idx == pat_last) ? 4'h0 : pat_idx + 4'h1;
                    next_state = cts_pkg::ST_DELAY;
                end
            end
            default:
            begin
                next_state = cts_pkg::ST_IDLE;
            end
        endcase
    end

    // Clock phases and fire level follow the coming state.
    always_comb
    begin
        next_ccd_clk = '0;
        next_fire = 1'b0;
        case (next_state)
            cts_pkg::ST_CLEAN:
            begin
                next_ccd_clk.image = ~ccd_clk.image;
                next_ccd_clk.storage = ~ccd_clk.storage;
                next_ccd_clk.horiz = ~ccd_clk.horiz;
            end
            cts_pkg::ST_DELAY:
            begin
                next_ccd_clk.horiz = ~ccd_clk.horiz;
                next_fire = 1'b1;
            end
            cts_pkg::ST_EXPOSE:
            begin
                next_ccd_clk.horiz = ~ccd_clk.horiz;
                next_fire = 1'b1;
            end
            cts_pkg::ST_SHIFT:
            begin
                next_ccd_clk.image = ~ccd_clk.image;
                next_ccd_clk.storage = ~ccd_clk.storage;
            end
            cts_pkg::ST_READ:
            begin
                next_ccd_clk.storage = ~ccd_clk.storage;
                next_ccd_clk.horiz = ~ccd_clk.horiz;
            end
            cts_pkg::ST_WAIT:
            begin
                next_ccd_clk.horiz = ~ccd_clk.horiz;
                next_fire = 1'b1;
            end
            default:
            begin
                next_fire = 1'b0;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= cts_pkg::ST_IDLE;
            act_mode <= cts_pkg::MODE_FT;
            cnt <= 32'h0000_0000;
            cleans <= 16'h0000;
            imgs <= 16'h0000;
            pat_idx <= 4'h0;
            exp_len <= 32'h0000_0001;
            hw_stop <= 1'b0;
            ccd_clk <= '0;
            fire <= 1'b0;
        end
        else
        begin
            state <= next_state;
            act_mode <= next_act_mode;
            cnt <= next_cnt;
            cleans <= next_cleans;
            imgs <= next_imgs;
            pat_idx <= next_pat_idx;
            exp_len <= next_exp_len;
            hw_stop <= next_hw_stop;
            ccd_clk <= next_ccd_clk;
            fire <= next_fire;
        end
    end

endmodule

// file: verilog/cts_trig_sync.sv
// Brings the trigger pin into the pclk domain and finds its edges.
module cts_trig_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trig_pin,
    output cts_pkg::cts_trig_t trig
);

    logic sync1;
    logic sync2;
    logic prev;
    logic next_sync1;
    logic next_sync2;
    logic next_prev;

    // The first stage feeds only the second stage.
    always_comb
    begin
        next_sync1 = trig_pin;
        next_sync2 = sync1;
        next_prev = sync2;
    end

    // Two synchroniser stages and the edge history flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    // Edge pulses last one cycle each.
    assign trig.level = sync2;
    assign trig.rise = sync2 & ~prev;
    assign trig.fall = ~sync2 & prev;

endmodule
